//--- common/clk_cfg_pkg.sv
// constants and types shared by the clock output configuration bank
package clk_cfg_pkg;
    //------------------------------------------------------------------
    // serial link
    //------------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR       = 7'h69;   // write address 0xd2
    localparam logic       DIR_WRITE      = 1'b0;
    localparam logic [7:0] CMD_CODE       = 8'h00;
    localparam int         BYTE_BITS      = 8;
    localparam logic [2:0] BIT_LAST       = 3'h7;
    localparam logic [5:0] MAX_DATA_BYTES = 6'h20;
    //------------------------------------------------------------------
    // configuration bytes
    //------------------------------------------------------------------
    localparam logic [5:0] IDX_MISC       = 6'h00;
    localparam logic [5:0] IDX_MEM        = 6'h01;
    localparam logic [5:0] IDX_PCI        = 6'h02;
    localparam int         BIT_SPREAD     = 3;
    localparam int         BIT_DOT        = 2;
    localparam int         BIT_USB        = 1;
    localparam int         BIT_DBGCPU     = 0;
    localparam logic [7:0] MISC_MASK      = 8'h0f;   // bits 7..4 reserved
    localparam logic [7:0] PCI_MASK       = 8'hfe;   // bit 0 reserved
    // power-on value: all outputs enabled, spread off
    localparam logic [7:0] MISC_RESET     = 8'h07;
    localparam logic [7:0] MEM_RESET      = 8'hff;
    localparam logic [7:0] PCI_RESET      = 8'hfe;
    // spread deviation in tenths of a percent, downward
    localparam int         SPREAD_DEV_PERMILLE = -5;
    //------------------------------------------------------------------
    // receiver states
    //------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_BYTE, ST_BYTE_ACK, ST_IGNORE
    } rx_state_t;
    typedef enum logic [1:0] {
        PH_CMD, PH_COUNT, PH_DATA
    } phase_t;
endpackage

//--- common/clk_gate_if.sv
// enables and clocks passed to the output gating module
`timescale 1ns/10ps
interface clk_gate_if #(parameter int N = 18);
    logic [N-1:0] enable;     // wanted enable per output
    logic [N-1:0] srcClk;     // free running source clocks
    logic [N-1:0] gatedClk;   // gated outputs
    modport ctrl (output enable, output srcClk, input gatedClk);
    modport gate (input enable, input srcClk, output gatedClk);
endinterface

//--- logic/clk_out_gate.sv
// glitch free gating of each output clock
`timescale 1ns/10ps
module clk_out_gate
    import clk_cfg_pkg::*;
#(
    parameter int N = 18
) (
    input  wire logic  mclk,
    input  wire logic  rst_b,
    clk_gate_if.gate   gif
);

    logic [N-1:0] enLive_ff;

    //------------------------------------------------------------------
    // per output gate
    //------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gen_gate
            // enable changes only while the source is low
            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    enLive_ff[g] <= 1'b0;
                end else if (!gif.srcClk[g]) begin
                    enLive_ff[g] <= gif.enable[g]; // R17
                end
            end
            // disabled output is driven low, never left floating
            assign gif.gatedClk[g] = gif.srcClk[g] & enLive_ff[g]; // R10
        end
    endgenerate
endmodule // clk_out_gate

//--- logic/clock_output_config_bank.sv
// serial write-only configuration bank steering the output clock enables
// Notes on behaviour
// [R1] bits are taken msb first and bytes fill upward from byte 0.
// [R2] the host writes zero into every reserved or unused bit.
// [R3] the host clears every initialise-to-zero bit when setting up.
// [R4] only bytes 0 to 2 act; bytes 3 to 7 are reserved and sent as zero.
// [R5] byte 0 bit 2 enables the dot clock, bit 1 usb, bit 0 debug cpu.
// [R6] byte 0 bit 3 turns spread spectrum on when set.
// [R7] with spread on the frequency is pulled down by half a percent.
// [R8] byte 1 bits 7..0 enable memory clocks 7..0.
// [R9] byte 2 bits 7..1 enable pci clocks 7..1, bit 0 reserved.
// [R10] a disabled output stops and is driven low.
// [R11] the host programs the enables once near power-on.
// [R12] only block writes to the device write address are answered.
// [R13] a zero command byte and a byte count precede the data, acked only.
// [R14] the byte count is 1 to 32 and matches the data bytes sent.
// [R15] only block writes, sequential from byte 0, may stop after any byte.
// [R16] a byte takes effect only after all eight bits and its ack.
// [R17] enables change only while the output is low.
`timescale 1ns/10ps
module clock_output_config_bank
    import clk_cfg_pkg::*;
#(
    parameter int N_MEM = 8,
    parameter int N_PCI = 7
) (
    input  wire logic             mclk,
    input  wire logic             rst_b,
    input  wire logic             sclkIn,
    input  wire logic             sdataIn,
    output      logic             sdataOut,
    output      logic             sdataOe_b,
    input  wire logic             dotClkSrc,
    input  wire logic             usbClkSrc,
    input  wire logic             debug_port_cpu_clock_src,
    input  wire logic [N_MEM-1:0] memClkSrc,
    input  wire logic [N_PCI-1:0] pciClkSrc,
    output      logic             dotClk,
    output      logic             usbClk,
    output      logic             debug_port_cpu_clock,
    output      logic [N_MEM-1:0] memClk,
    output      logic [N_PCI-1:0] pciClk,
    output      logic             spreadEnable
);
    localparam int NOUT = 3 + N_MEM + N_PCI;

    //------------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------------
    logic [1:0] sclkSync_ff;
    logic [1:0] sdaSync_ff;
    logic       sclkDly_ff;
    logic       sdaDly_ff;

    // two stages, then a delayed copy for edge finding
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sclkSync_ff <= 2'h3;
            sdaSync_ff  <= 2'h3;
            sclkDly_ff  <= 1'b1;
            sdaDly_ff   <= 1'b1;
        end else begin
            sclkSync_ff <= {sclkSync_ff[0], sclkIn};
            sdaSync_ff  <= {sdaSync_ff[0], sdataIn};
            sclkDly_ff  <= sclkSync_ff[1];
            sdaDly_ff   <= sdaSync_ff[1];
        end
    end

    wire sclk     = sclkSync_ff[1];
    wire sda      = sdaSync_ff[1];
    wire sclkRise = sclk & ~sclkDly_ff;
    wire sclkFall = ~sclk & sclkDly_ff;
    wire startCnd = sclk & sclkDly_ff & sdaDly_ff & ~sda;
    wire stopCnd  = sclk & sclkDly_ff & ~sdaDly_ff & sda;

    //------------------------------------------------------------------
    // receiver state
    //------------------------------------------------------------------
    rx_state_t  state_ff,   nxt_state;
    phase_t     phase_ff,   nxt_phase;
    logic [7:0] shift_ff,   nxt_shift;
    logic [2:0] bitCnt_ff,  nxt_bitCnt;
    logic [5:0] byteIdx_ff, nxt_byteIdx;
    logic       ackDrv_ff,  nxt_ackDrv;
    logic       commit_ff,  nxt_commit;
    logic [7:0] misc_ff, mem_ff, pci_ff;

    wire [7:0] shiftNext = {shift_ff[6:0], sda};  // msb arrives first
    wire       lastBit   = (bitCnt_ff == BIT_LAST);
    wire       addrHit   = (shiftNext[7:1] == DEV_ADDR) &&
                           (shiftNext[0] == DIR_WRITE);
    wire       inRange   = (byteIdx_ff < MAX_DATA_BYTES);

    // next state of the serial receiver
    always_comb begin
        nxt_state   = state_ff;
        nxt_phase   = phase_ff;
        nxt_shift   = shift_ff;
        nxt_bitCnt  = bitCnt_ff;
        nxt_byteIdx = byteIdx_ff;
        nxt_ackDrv  = ackDrv_ff;
        nxt_commit  = 1'b0;
        if (startCnd) begin
            nxt_state  = ST_ADDR;
            nxt_bitCnt = '0;
            nxt_ackDrv = 1'b0;
        end else if (stopCnd) begin
            nxt_state  = ST_IDLE;      // stop after any complete byte R15
            nxt_ackDrv = 1'b0;
        end else begin
            case (state_ff)
                ST_ADDR: begin
                    if (sclkRise) begin
                        nxt_shift  = shiftNext;
                        nxt_bitCnt = bitCnt_ff + 3'h1;
                        if (lastBit) begin
                            nxt_state = addrHit ? ST_ADDR_ACK
                                                : ST_IGNORE; // R12
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (sclkFall) begin
                        nxt_ackDrv = ~ackDrv_ff;
                        if (ackDrv_ff) begin
                            nxt_state   = ST_BYTE;
                            nxt_phase   = PH_CMD;
                            nxt_byteIdx = '0;
                        end
                    end
                end
                ST_BYTE: begin
                    if (sclkRise) begin
                        nxt_shift  = shiftNext;        // R1
                        nxt_bitCnt = bitCnt_ff + 3'h1;
                        if (lastBit) begin
                            nxt_state = ST_BYTE_ACK;
                        end
                    end
                end
                ST_BYTE_ACK: begin
                    if (sclkFall) begin
                        nxt_ackDrv = ~ackDrv_ff;
                        if (ackDrv_ff) begin
                            // ack done: the byte is complete R16
                            nxt_state = ST_BYTE;
                            case (phase_ff)
                                PH_CMD:   nxt_phase = PH_COUNT; // R13
                                PH_COUNT: nxt_phase = PH_DATA;  // R13
                                PH_DATA: begin
                                    nxt_commit  = 1'b1;
                                    // index holds at the limit, never wraps
                                    if (inRange) begin
                                        nxt_byteIdx = byteIdx_ff + 6'h1;
                                    end
                                end
                                default:  nxt_phase = PH_CMD;
                            endcase
                        end
                    end
                end
                ST_IGNORE: nxt_state = ST_IGNORE;
                default:   nxt_state = ST_IDLE;
            endcase
        end
    end

    // receiver registers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff   <= ST_IDLE;
            phase_ff   <= PH_CMD;
            shift_ff   <= '0;
            bitCnt_ff  <= '0;
            byteIdx_ff <= '0;
            ackDrv_ff  <= 1'b0;
            commit_ff  <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            phase_ff   <= nxt_phase;
            shift_ff   <= nxt_shift;
            bitCnt_ff  <= nxt_bitCnt;
            byteIdx_ff <= nxt_byteIdx;
            ackDrv_ff  <= nxt_ackDrv;
            commit_ff  <= nxt_commit & inRange;
        end
    end

    //------------------------------------------------------------------
    // configuration bytes
    //------------------------------------------------------------------
    wire [5:0] wrIdx  = byteIdx_ff - 6'h1;
    wire       wrMisc = commit_ff && (wrIdx == IDX_MISC);
    wire       wrMem  = commit_ff && (wrIdx == IDX_MEM);
    wire       wrPci  = commit_ff && (wrIdx == IDX_PCI);

    // bytes 3 and up are acked and dropped R4
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            misc_ff <= MISC_RESET;
            mem_ff  <= MEM_RESET;
            pci_ff  <= PCI_RESET;
        end else begin
            if (wrMisc) misc_ff <= shift_ff & MISC_MASK; // R5
            if (wrMem)  mem_ff  <= shift_ff;             // R8
            if (wrPci)  pci_ff  <= shift_ff & PCI_MASK;  // R9
        end
    end

    // spread request; the synthesiser applies the downward deviation R7
    assign spreadEnable = misc_ff[BIT_SPREAD]; // R6 R7

    // ack pulls the data line low; otherwise released
    assign sdataOut  = 1'b0;
    assign sdataOe_b = ~ackDrv_ff;

    //------------------------------------------------------------------
    // output gating
    //------------------------------------------------------------------
    clk_gate_if #(.N(NOUT)) gif ();

    assign gif.enable = {pci_ff[7:1], mem_ff, misc_ff[BIT_DOT],
                         misc_ff[BIT_USB], misc_ff[BIT_DBGCPU]}; // R5 R8 R9
    assign gif.srcClk = {pciClkSrc, memClkSrc, dotClkSrc, usbClkSrc,
                         debug_port_cpu_clock_src};

    clk_out_gate #(.N(NOUT)) u_gate (
        .mclk  (mclk),
        .rst_b (rst_b),
        .gif   (gif)
    );

    assign debug_port_cpu_clock = gif.gatedClk[0];
    assign usbClk               = gif.gatedClk[1];
    assign dotClk               = gif.gatedClk[2];
    assign memClk               = gif.gatedClk[3 +: N_MEM];
    assign pciClk               = gif.gatedClk[3 + N_MEM +: N_PCI];
endmodule // clock_output_config_bank

//--- test/clock_output_config_bank_checker.sv
// port assertions for the clock output configuration bank
`timescale 1ns/10ps
module clock_output_config_bank_checker #(
    parameter int N_MEM = 8,
    parameter int N_PCI = 7
) (
    input wire logic             mclk,
    input wire logic             rst_b,
    input wire logic             sclkIn,
    input wire logic             sdataOut,
    input wire logic             sdataOe_b,
    input wire logic             dotClkSrc,
    input wire logic             usbClkSrc,
    input wire logic             debug_port_cpu_clock_src,
    input wire logic [N_MEM-1:0] memClkSrc,
    input wire logic [N_PCI-1:0] pciClkSrc,
    input wire logic             dotClk,
    input wire logic             usbClk,
    input wire logic             debug_port_cpu_clock,
    input wire logic [N_MEM-1:0] memClk,
    input wire logic [N_PCI-1:0] pciClk,
    input wire logic             spreadEnable
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic [3:0] sinceAck_ff;
    // cycles since the device last pulled the data line for an ack
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) sinceAck_ff <= 4'hf;
        else if (!sdataOe_b) sinceAck_ff <= 4'h0;
        else if (sinceAck_ff != 4'hf) sinceAck_ff <= sinceAck_ff + 4'h1;
    end
    a_spread_at_reset: assert property ($rose(rst_b) |-> !spreadEnable)
        else $error("spread on right after reset");
    a_misc_gated: assert property (({dotClk, usbClk, debug_port_cpu_clock}
        & ~{dotClkSrc, usbClkSrc, debug_port_cpu_clock_src}) == 3'h0)
        else $error("misc output high without its source");
    a_mem_gated: assert property ((memClk & ~memClkSrc) == '0)
        else $error("memory clock high without its source");
    a_pci_gated: assert property ((pciClk & ~pciClkSrc) == '0)
        else $error("pci clock high without its source");
    a_usb_rise_src: assert property ($rose(usbClk) |-> $rose(usbClkSrc))
        else $error("usb clock rose off a source edge");
    a_mem_fall_src: assert property ($fell(memClk[0]) |-> $fell(memClkSrc[0]))
        else $error("memory clock cut short");
    a_ack_in_low: assert property ($fell(sdataOe_b) |-> !sclkIn)
        else $error("ack started with clock high");
    a_ack_hold_end: assert property ($fell(sdataOe_b) |->
        !sdataOe_b [*4] ##[1:40] sdataOe_b)
        else $error("ack length wrong");
    a_pin_drive_low: assert property (!sdataOe_b |-> !sdataOut)
        else $error("data pin driven high");
    a_spread_after_ack: assert property ($changed(spreadEnable) |->
        sinceAck_ff <= 4'h8)
        else $error("spread changed without a whole byte");
endmodule // clock_output_config_bank_checker

//--- test/serial_host_model.sv
// host controller model issuing serial block writes
`timescale 1ns/10ps
module serial_host_model (
    input  wire logic mclk,
    input  wire logic sdataOut,
    input  wire logic sdataOe_b,
    output      logic sclkIn,
    output      logic sdataIn
);
    logic hostLow;
    // wired-and of both open-drain drivers with a pull-up
    assign sdataIn = ~hostLow & (sdataOe_b | sdataOut);
    initial begin
        sclkIn = 1'b1;
        hostLow = 1'b0;
    end
    task automatic waitClk(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // start: data falls while the link clock is high
    task automatic start();
        waitClk(2);
        hostLow = 1'b1;
        waitClk(3);
        sclkIn = 1'b0;
    endtask
    // stop: data rises while high, link clock then stands still
    task automatic stop();
        waitClk(1);
        hostLow = 1'b1;
        waitClk(4);
        sclkIn = 1'b1;
        waitClk(3);
        hostLow = 1'b0;
        waitClk(4);
    endtask
    // n bits msb first, then an ack slot once the byte is whole
    task automatic sendBits(input logic [7:0] b, input int n,
                            output logic ack);
        ack = 1'b0;
        for (int i = 7; i > 7 - n; i--) begin
            waitClk(1);
            hostLow = ~b[i];
            waitClk(4);
            sclkIn = 1'b1;
            waitClk(3);
            sclkIn = 1'b0;
        end
        if (n == 8) begin
            waitClk(1);
            hostLow = 1'b0;
            waitClk(4);
            sclkIn = 1'b1;
            waitClk(3);
            ack = ~sdataIn;
            sclkIn = 1'b0;
        end
    endtask
endmodule // serial_host_model

//--- test/tb_clock_output_config_bank.sv
// bench for the clock output configuration bank
`timescale 1ns/10ps
module tb_clock_output_config_bank;
    import clk_cfg_pkg::*;
    logic       mclk, rst_b, sclkIn, sdataIn, sdataOut, sdataOe_b;
    logic       dotClk, usbClk, dbgClk, spreadEnable;
    logic [7:0] memClk;
    logic [6:0] pciClk;
    logic [3:0] srcCnt = 4'h0;
    int         num_errors = 0;
    int         n_checks = 0;
    wire        srcClk = srcCnt[3];
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // slow source clocks, sixteen system clocks a period
    always @(negedge mclk) srcCnt <= srcCnt + 4'h1;
    clock_output_config_bank DUT (.mclk(mclk), .rst_b(rst_b),
        .sclkIn(sclkIn), .sdataIn(sdataIn), .sdataOut(sdataOut),
        .sdataOe_b(sdataOe_b), .dotClkSrc(srcClk), .usbClkSrc(srcClk),
        .debug_port_cpu_clock_src(srcClk), .memClkSrc({8{srcClk}}),
        .pciClkSrc({7{srcClk}}), .dotClk(dotClk), .usbClk(usbClk),
        .debug_port_cpu_clock(dbgClk), .memClk(memClk), .pciClk(pciClk),
        .spreadEnable(spreadEnable));
    serial_host_model host (.mclk(mclk), .sdataOut(sdataOut),
        .sdataOe_b(sdataOe_b), .sclkIn(sclkIn), .sdataIn(sdataIn));
    task automatic check(input logic [31:0] got, exp, input string what);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // outputs seen high over two and a half source periods must match the enables
    task automatic checkOuts(input logic [7:0] b0, b1, b2, input string t);
        logic [17:0] seen;
        seen = '0;
        repeat (40) begin
            // falling edge: outputs settled since the last rising edge
            @(negedge mclk);
            seen |= {dotClk, usbClk, dbgClk, memClk, pciClk};
        end
        check(32'(seen), 32'({b0[2:0], b1, b2[7:1]}), "enables");
        check(32'(spreadEnable), 32'(b0[3]), "spread");
        $display("test %s done", t);
    endtask
    // address, command, count, n data bytes, then cut bits of one more
    task automatic frame(input logic [7:0] a, input logic [7:0] d [8],
                         input int n, input int cut, input logic ackExp);
        logic ack;
        host.start();
        host.sendBits(a, 8, ack);
        check(32'(ack), 32'(ackExp), "address ack");
        host.sendBits(CMD_CODE, 8, ack);
        check(32'(ack), 32'(ackExp), "command ack");
        host.sendBits(8'(n), 8, ack);
        check(32'(ack), 32'(ackExp), "count ack");
        for (int i = 0; i < n; i++) begin
            host.sendBits(d[i], 8, ack);
            check(32'(ack), 32'(ackExp), "data ack");
        end
        if (cut > 0) host.sendBits(d[n], cut, ack);
        host.stop();
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // main sequence
    initial begin
        rst_b = 1'b0;
        repeat (2) @(negedge mclk);
        rst_b = 1'b1;
        repeat (4) @(negedge mclk);
        checkOuts(MISC_RESET, MEM_RESET, PCI_RESET, "reset");
        // reserved bits and bytes 3..7 sent as zero, set up once at start
        frame({DEV_ADDR, DIR_WRITE}, '{8'h0a, 8'h35, 8'ha4, 8'h00, 8'h00,
              8'h00, 8'h00, 8'h00}, 8, 0, 1'b1);
        checkOuts(8'h0a, 8'h35, 8'ha4, "full");
        frame(8'hd4, '{8'h07, 8'hff, 8'hfe, 8'h00, 8'h00, 8'h00, 8'h00,
              8'h00}, 3, 0, 1'b0);
        checkOuts(8'h0a, 8'h35, 8'ha4, "address");
        frame(8'hd2, '{8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
              8'h00}, 1, 0, 1'b1);
        checkOuts(8'h05, 8'h35, 8'ha4, "short");
        frame(8'hd2, '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
              8'h00}, 1, 4, 1'b1);
        checkOuts(8'h08, 8'h35, 8'ha4, "partial");
        frame(8'hd2, '{8'h07, 8'hff, 8'hfe, 8'h00, 8'h00, 8'h00, 8'h00,
              8'h00}, 3, 0, 1'b1);
        checkOuts(8'h07, 8'hff, 8'hfe, "restore");
        give_verdict();
    end
    // watchdog, well beyond the expected run
    initial begin
        #2000000;
        num_errors++;
        give_verdict();
    end
endmodule // tb_clock_output_config_bank
bind clock_output_config_bank clock_output_config_bank_checker #(
    .N_MEM(N_MEM), .N_PCI(N_PCI)) chk (.mclk(mclk), .rst_b(rst_b),
    .sclkIn(sclkIn), .sdataOut(sdataOut), .sdataOe_b(sdataOe_b),
    .dotClkSrc(dotClkSrc), .usbClkSrc(usbClkSrc),
    .debug_port_cpu_clock_src(debug_port_cpu_clock_src),
    .memClkSrc(memClkSrc), .pciClkSrc(pciClkSrc), .dotClk(dotClk),
    .usbClk(usbClk), .debug_port_cpu_clock(debug_port_cpu_clock),
    .memClk(memClk), .pciClk(pciClk), .spreadEnable(spreadEnable));
